/* File: pmux_regs.vh */
`ifndef PMUX_REGS_VH
`define PMUX_REGS_VH

// port b pin positions
`define PMUX_PB_SS 0
`define PMUX_PB_SCK 1
`define PMUX_PB_MOSI 2
`define PMUX_PB_MISO 3
`define PMUX_PB_CMP0 4
`define PMUX_PB_CMP1A 5
`define PMUX_PB_CMP1B 6
`define PMUX_PB_OC7 7

// port d pin positions
`define PMUX_PD_IRQ2 2
`define PMUX_PD_IRQ3 3
`define PMUX_PD_CAP1 4
`define PMUX_PD_XCK 5
`define PMUX_PD_CNT1 6
`define PMUX_PD_CNT2 7

// address-mask thresholds, one per port c bit, bit 7 first
`define PMUX_AMASK_THR_7 3'h1
`define PMUX_AMASK_THR_6 3'h2
`define PMUX_AMASK_THR_5 3'h3
`define PMUX_AMASK_THR_4 3'h4
`define PMUX_AMASK_THR_3 3'h5
`define PMUX_AMASK_THR_2 3'h6
`define PMUX_AMASK_THR_1 3'h7
`define PMUX_AMASK_THR_0 3'h7
`define PMUX_AMASK_LEGACY 3'h0

// reset values of the registered pin controls and peripheral inputs
`define PMUX_PULLUP_RST 8'h00
`define PMUX_DIR_RST 8'h00
`define PMUX_VAL_RST 8'h00
`define PMUX_PC_DIR_RST 8'hFF
`define PMUX_PERIPH_RST 1'h0

`endif

/* File: pmux_pin_ovr.v */
`timescale 1ns/1ps
// one pin: override signals sit in front of the port registers
module pmux_pin_ovr (
  input wire pu_off_i,
  input wire dir_i,
  input wire out_i,
  input wire pu_ovr_en_i,
  input wire pu_ovr_val_i,
  input wire dir_ovr_en_i,
  input wire dir_ovr_val_i,
  input wire val_ovr_en_i,
  input wire val_ovr_val_i,
  output wire pullup_o,
  output wire dir_o,
  output wire val_o
);
  wire dir_eff;
  assign dir_eff = dir_ovr_en_i ? dir_ovr_val_i : dir_i;
  assign dir_o = dir_eff;
  assign val_o = val_ovr_en_i ? val_ovr_val_i : out_i;
  // pull-up only ever acts on an input pin
  assign pullup_o = pu_ovr_en_i ? pu_ovr_val_i :
                    (out_i & ~dir_i & ~pu_off_i);
endmodule

/* File: pmux_addr_mask.v */
`timescale 1ns/1ps
`include "pmux_regs.vh"
// which port c pins the external memory interface takes
module pmux_addr_mask (
  input wire mem_en_i,
  input wire compat_i,
  input wire [2:0] mask_i,
  output wire [7:0] take_o
);
  wire [2:0] mask_eff;
  assign mask_eff = compat_i ? `PMUX_AMASK_LEGACY : mask_i;
  assign take_o[7] = mem_en_i & (mask_eff < `PMUX_AMASK_THR_7);
  assign take_o[6] = mem_en_i & (mask_eff < `PMUX_AMASK_THR_6);
  assign take_o[5] = mem_en_i & (mask_eff < `PMUX_AMASK_THR_5);
  assign take_o[4] = mem_en_i & (mask_eff < `PMUX_AMASK_THR_4);
  assign take_o[3] = mem_en_i & (mask_eff < `PMUX_AMASK_THR_3);
  assign take_o[2] = mem_en_i & (mask_eff < `PMUX_AMASK_THR_2);
  assign take_o[1] = mem_en_i & (mask_eff < `PMUX_AMASK_THR_1);
  assign take_o[0] = mem_en_i & (mask_eff < `PMUX_AMASK_THR_0);
endmodule

/* File: pmux_top.v */
`timescale 1ns/1ps
`include "pmux_regs.vh"

// What this block does
// - serial slave enabled forces slave-select pin to input
// - serial slave is active only while slave-select is held low
// - master: select direction from its bit; forced pull-up follows port
// - miso from master-in/slave-out; mosi split into master-out/slave-in
// - port b 7..4: no pull-up/direction override; compare drives value
// - port b 3..0 gated by enable and master; pull-up port and not off
// - miso, mosi, clock driven from serial; select value never overridden
// - legacy mode makes port c output only, active from power-up
// - port c pins 7..0 carry address bits 15..8
// - port c 7..4 taken when memory on and mask below 1..4
// - port c 3..0 taken when mask below 5,6,7,7
// - legacy mode treats the address mask as zero
// - port d 7,6 feed timer count inputs, bit 4 timer1 capture
// - usart1 clock pin only in synchronous mode; direction bit picks way
// - usart1 transmitter enabled forces transmit pin to output
// - usart1 receiver enabled forces receive pin input, pull-up from port
// - port d 3 and 2 feed external interrupt sources 3 and 2
// - legacy mode drops usart1 pins and timer1 compare c
module pmux_top (
  input wire mclk_i,
  input wire rst_i,
  input wire compat_mode_i,
  input wire global_pullup_disable_i,
  input wire [7:0] portb_direction_i,
  input wire [7:0] portb_output_value_i,
  input wire [7:0] portb_pin_i,
  input wire [7:0] portc_direction_i,
  input wire [7:0] portc_output_value_i,
  input wire [7:0] portd_direction_i,
  input wire [7:0] portd_output_value_i,
  input wire [7:0] portd_pin_i,
  input wire timer0_compare_out_i,
  input wire timer0_compare_en_i,
  input wire timer1_compare_out_a_i,
  input wire timer1_compare_en_a_i,
  input wire timer1_compare_out_b_i,
  input wire timer1_compare_en_b_i,
  input wire timer1_compare_out_c_i,
  input wire timer1_compare_en_c_i,
  input wire timer2_compare_out_i,
  input wire timer2_compare_en_i,
  input wire serial_periph_on_i,
  input wire serial_master_select_i,
  input wire serial_slave_data_i,
  input wire serial_master_data_i,
  input wire serial_clock_out_i,
  input wire ext_memory_enable_i,
  input wire [2:0] ext_address_mask_i,
  input wire [7:0] ext_address_high_i,
  input wire usart1_sync_mode_i,
  input wire usart1_ext_clock_out_i,
  input wire usart1_tx_enable_i,
  input wire usart1_tx_data_i,
  input wire usart1_rx_enable_i,
  output reg [7:0] portb_pullup_o,
  output reg [7:0] portb_dir_o,
  output reg [7:0] portb_val_o,
  output reg [7:0] portc_pullup_o,
  output reg [7:0] portc_dir_o,
  output reg [7:0] portc_val_o,
  output reg [7:0] portd_pullup_o,
  output reg [7:0] portd_dir_o,
  output reg [7:0] portd_val_o,
  output reg serial_master_in_o,
  output reg serial_slave_in_o,
  output reg serial_clock_in_o,
  output reg serial_slave_active_o,
  output reg timer2_count_in_o,
  output reg timer1_count_in_o,
  output reg timer1_capture_in_o,
  output reg usart1_ext_clock_in_o,
  output reg usart1_clock_is_out_o,
  output reg usart1_receive_in_o,
  output reg ext_irq_source_3_o,
  output reg ext_irq_source_2_o
);

  wire pu_off;
  wire spi_slave;
  wire spi_master;
  wire cmp1c_en_eff;
  wire xck_on;
  wire tx_on;
  wire rx_on;
  wire [7:0] pc_take;
  wire [7:0] pc_dir_reg;

  wire [7:0] b_pu_en;
  wire [7:0] b_pu_val;
  wire [7:0] b_dr_en;
  wire [7:0] b_dr_val;
  wire [7:0] b_vl_en;
  wire [7:0] b_vl_val;
  wire [7:0] b_pullup_d;
  wire [7:0] b_dir_d;
  wire [7:0] b_val_d;

  wire [7:0] c_pullup_d;
  wire [7:0] c_dir_d;
  wire [7:0] c_val_d;

  wire [7:0] d_pu_en;
  wire [7:0] d_pu_val;
  wire [7:0] d_dr_en;
  wire [7:0] d_dr_val;
  wire [7:0] d_vl_en;
  wire [7:0] d_vl_val;
  wire [7:0] d_pullup_d;
  wire [7:0] d_dir_d;
  wire [7:0] d_val_d;

  assign pu_off = global_pullup_disable_i;
  assign spi_slave = serial_periph_on_i & ~serial_master_select_i;
  assign spi_master = serial_periph_on_i & serial_master_select_i;

  // ---- port b ----
  // no compare c legacy
  assign cmp1c_en_eff = timer1_compare_en_c_i & ~compat_mode_i;

  assign b_pu_en[7:4] = 4'h0;
  assign b_pu_val[7:4] = 4'h0;
  assign b_dr_en[7:4] = 4'h0;
  assign b_dr_val[7:4] = 4'h0;
  // both compare sources on bit 7 are merged by or, as a modulator would
  assign b_vl_en[`PMUX_PB_OC7] = timer2_compare_en_i | cmp1c_en_eff;
  assign b_vl_val[`PMUX_PB_OC7] = (timer2_compare_en_i & timer2_compare_out_i) |
                                  (cmp1c_en_eff & timer1_compare_out_c_i);
  assign b_vl_en[`PMUX_PB_CMP1B] = timer1_compare_en_b_i;
  assign b_vl_val[`PMUX_PB_CMP1B] = timer1_compare_out_b_i;
  assign b_vl_en[`PMUX_PB_CMP1A] = timer1_compare_en_a_i;
  assign b_vl_val[`PMUX_PB_CMP1A] = timer1_compare_out_a_i;
  assign b_vl_en[`PMUX_PB_CMP0] = timer0_compare_en_i;
  assign b_vl_val[`PMUX_PB_CMP0] = timer0_compare_out_i;

  assign b_pu_en[`PMUX_PB_MISO] = spi_master;
  assign b_dr_en[`PMUX_PB_MISO] = spi_master;
  assign b_pu_val[`PMUX_PB_MISO] = portb_output_value_i[`PMUX_PB_MISO] & ~pu_off;
  assign b_dr_val[`PMUX_PB_MISO] = 1'h0;
  assign b_pu_en[`PMUX_PB_MOSI] = spi_slave;
  assign b_dr_en[`PMUX_PB_MOSI] = spi_slave;
  assign b_pu_val[`PMUX_PB_MOSI] = portb_output_value_i[`PMUX_PB_MOSI] & ~pu_off;
  assign b_dr_val[`PMUX_PB_MOSI] = 1'h0;
  assign b_pu_en[`PMUX_PB_SCK] = spi_slave;
  assign b_dr_en[`PMUX_PB_SCK] = spi_slave;
  assign b_pu_val[`PMUX_PB_SCK] = portb_output_value_i[`PMUX_PB_SCK] & ~pu_off;
  assign b_dr_val[`PMUX_PB_SCK] = 1'h0;
  assign b_dr_en[`PMUX_PB_SS] = spi_slave;
  assign b_dr_val[`PMUX_PB_SS] = 1'h0;
  assign b_pu_en[`PMUX_PB_SS] = spi_slave;
  assign b_pu_val[`PMUX_PB_SS] = portb_output_value_i[`PMUX_PB_SS] & ~pu_off;

  assign b_vl_en[`PMUX_PB_MISO] = spi_slave;
  assign b_vl_val[`PMUX_PB_MISO] = serial_slave_data_i;
  assign b_vl_en[`PMUX_PB_MOSI] = spi_master;
  assign b_vl_val[`PMUX_PB_MOSI] = serial_master_data_i;
  assign b_vl_en[`PMUX_PB_SCK] = spi_master;
  assign b_vl_val[`PMUX_PB_SCK] = serial_clock_out_i;
  assign b_vl_en[`PMUX_PB_SS] = 1'h0;
  assign b_vl_val[`PMUX_PB_SS] = 1'h0;

  // ---- port c ----
  // legacy output only
  assign pc_dir_reg = compat_mode_i ? 8'hFF : portc_direction_i;

  pmux_addr_mask u_mask (
    .mem_en_i(ext_memory_enable_i),
    .compat_i(compat_mode_i),
    .mask_i(ext_address_mask_i),
    .take_o(pc_take)
  );

  // ---- port d ----
  // no usart1 legacy
  assign xck_on = usart1_sync_mode_i & ~compat_mode_i;
  assign tx_on = usart1_tx_enable_i & ~compat_mode_i;
  assign rx_on = usart1_rx_enable_i & ~compat_mode_i;

  assign d_pu_en[7:4] = 4'h0;
  assign d_pu_val[7:4] = 4'h0;
  assign d_dr_en[7:4] = 4'h0;
  assign d_dr_val[7:4] = 4'h0;
  assign d_vl_en[`PMUX_PD_CNT2] = 1'h0;
  assign d_vl_val[`PMUX_PD_CNT2] = 1'h0;
  assign d_vl_en[`PMUX_PD_CNT1] = 1'h0;
  assign d_vl_val[`PMUX_PD_CNT1] = 1'h0;
  assign d_vl_en[`PMUX_PD_CAP1] = 1'h0;
  assign d_vl_val[`PMUX_PD_CAP1] = 1'h0;
  assign d_vl_en[`PMUX_PD_XCK] = xck_on;
  assign d_vl_val[`PMUX_PD_XCK] = usart1_ext_clock_out_i;

  assign d_pu_en[`PMUX_PD_IRQ3] = tx_on;
  assign d_pu_val[`PMUX_PD_IRQ3] = 1'h0;
  assign d_dr_en[`PMUX_PD_IRQ3] = tx_on;
  assign d_dr_val[`PMUX_PD_IRQ3] = 1'h1;
  assign d_vl_en[`PMUX_PD_IRQ3] = tx_on;
  assign d_vl_val[`PMUX_PD_IRQ3] = usart1_tx_data_i;
  assign d_pu_en[`PMUX_PD_IRQ2] = rx_on;
  assign d_pu_val[`PMUX_PD_IRQ2] = portd_output_value_i[`PMUX_PD_IRQ2] & ~pu_off;
  assign d_dr_en[`PMUX_PD_IRQ2] = rx_on;
  assign d_dr_val[`PMUX_PD_IRQ2] = 1'h0;
  assign d_vl_en[`PMUX_PD_IRQ2] = 1'h0;
  assign d_vl_val[`PMUX_PD_IRQ2] = 1'h0;
  // two-wire pins are outside this block: registers pass through
  assign d_pu_en[1:0] = 2'h0;
  assign d_pu_val[1:0] = 2'h0;
  assign d_dr_en[1:0] = 2'h0;
  assign d_dr_val[1:0] = 2'h0;
  assign d_vl_en[1:0] = 2'h0;
  assign d_vl_val[1:0] = 2'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      pmux_pin_ovr u_b (
        .pu_off_i(pu_off),
        .dir_i(portb_direction_i[gi]),
        .out_i(portb_output_value_i[gi]),
        .pu_ovr_en_i(b_pu_en[gi]),
        .pu_ovr_val_i(b_pu_val[gi]),
        .dir_ovr_en_i(b_dr_en[gi]),
        .dir_ovr_val_i(b_dr_val[gi]),
        .val_ovr_en_i(b_vl_en[gi]),
        .val_ovr_val_i(b_vl_val[gi]),
        .pullup_o(b_pullup_d[gi]),
        .dir_o(b_dir_d[gi]),
        .val_o(b_val_d[gi])
      );
      pmux_pin_ovr u_c (
        .pu_off_i(pu_off),
        .dir_i(pc_dir_reg[gi]),
        .out_i(portc_output_value_i[gi]),
        .pu_ovr_en_i(pc_take[gi]),
        .pu_ovr_val_i(1'h0),
        .dir_ovr_en_i(pc_take[gi]),
        .dir_ovr_val_i(1'h1),
        .val_ovr_en_i(pc_take[gi]),
        .val_ovr_val_i(ext_address_high_i[gi]),
        .pullup_o(c_pullup_d[gi]),
        .dir_o(c_dir_d[gi]),
        .val_o(c_val_d[gi])
      );
      pmux_pin_ovr u_d (
        .pu_off_i(pu_off),
        .dir_i(portd_direction_i[gi]),
        .out_i(portd_output_value_i[gi]),
        .pu_ovr_en_i(d_pu_en[gi]),
        .pu_ovr_val_i(d_pu_val[gi]),
        .dir_ovr_en_i(d_dr_en[gi]),
        .dir_ovr_val_i(d_dr_val[gi]),
        .val_ovr_en_i(d_vl_en[gi]),
        .val_ovr_val_i(d_vl_val[gi]),
        .pullup_o(d_pullup_d[gi]),
        .dir_o(d_dir_d[gi]),
        .val_o(d_val_d[gi])
      );
    end
  endgenerate

  // pin controls, registered so every output starts at a flip-flop
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      portb_pullup_o <= `PMUX_PULLUP_RST;
      portb_dir_o <= `PMUX_DIR_RST;
      portb_val_o <= `PMUX_VAL_RST;
      portc_pullup_o <= `PMUX_PULLUP_RST;
      // port c wakes as outputs, matching the factory legacy setting
      portc_dir_o <= `PMUX_PC_DIR_RST;
      portc_val_o <= `PMUX_VAL_RST;
      portd_pullup_o <= `PMUX_PULLUP_RST;
      portd_dir_o <= `PMUX_DIR_RST;
      portd_val_o <= `PMUX_VAL_RST;
    end else begin
      portb_pullup_o <= b_pullup_d;
      portb_dir_o <= b_dir_d;
      portb_val_o <= b_val_d;
      portc_pullup_o <= c_pullup_d;
      portc_dir_o <= c_dir_d;
      portc_val_o <= c_val_d;
      portd_pullup_o <= d_pullup_d;
      portd_dir_o <= d_dir_d;
      portd_val_o <= d_val_d;
    end
  end

  // inputs handed to peripherals
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_master_in_o <= `PMUX_PERIPH_RST;
      serial_slave_in_o <= `PMUX_PERIPH_RST;
      serial_clock_in_o <= `PMUX_PERIPH_RST;
      serial_slave_active_o <= `PMUX_PERIPH_RST;
      timer2_count_in_o <= `PMUX_PERIPH_RST;
      timer1_count_in_o <= `PMUX_PERIPH_RST;
      timer1_capture_in_o <= `PMUX_PERIPH_RST;
      usart1_ext_clock_in_o <= `PMUX_PERIPH_RST;
      usart1_clock_is_out_o <= `PMUX_PERIPH_RST;
      usart1_receive_in_o <= `PMUX_PERIPH_RST;
      ext_irq_source_3_o <= `PMUX_PERIPH_RST;
      ext_irq_source_2_o <= `PMUX_PERIPH_RST;
    end else begin
      serial_master_in_o <= portb_pin_i[`PMUX_PB_MISO];
      serial_slave_in_o <= portb_pin_i[`PMUX_PB_MOSI];
      serial_clock_in_o <= portb_pin_i[`PMUX_PB_SCK];
      serial_slave_active_o <= spi_slave & ~portb_pin_i[`PMUX_PB_SS];
      timer2_count_in_o <= portd_pin_i[`PMUX_PD_CNT2];
      timer1_count_in_o <= portd_pin_i[`PMUX_PD_CNT1];
      timer1_capture_in_o <= portd_pin_i[`PMUX_PD_CAP1];
      usart1_ext_clock_in_o <= xck_on & portd_pin_i[`PMUX_PD_XCK];
      usart1_clock_is_out_o <= xck_on & portd_direction_i[`PMUX_PD_XCK];
      usart1_receive_in_o <= rx_on & portd_pin_i[`PMUX_PD_IRQ2];
      ext_irq_source_3_o <= portd_pin_i[`PMUX_PD_IRQ3];
      ext_irq_source_2_o <= portd_pin_i[`PMUX_PD_IRQ2];
    end
  end

endmodule

/* File: pmux_checker.sv */
`timescale 1ns/1ps
module pmux_checker (
  input wire mclk_i,
  input wire rst_i,
  input wire compat_mode_i,
  input wire serial_periph_on_i,
  input wire serial_master_select_i,
  input wire serial_slave_data_i,
  input wire [7:0] portb_direction_i,
  input wire [7:0] portb_pin_i,
  input wire ext_memory_enable_i,
  input wire [7:0] ext_address_high_i,
  input wire usart1_tx_enable_i,
  input wire usart1_tx_data_i,
  input wire [7:0] portb_dir_o,
  input wire [7:0] portb_val_o,
  input wire [7:0] portc_dir_o,
  input wire [7:0] portc_val_o,
  input wire [7:0] portd_dir_o,
  input wire [7:0] portd_val_o,
  input wire serial_slave_active_o
);
  wire slv = serial_periph_on_i & ~serial_master_select_i;
  wire mst = serial_periph_on_i & serial_master_select_i;
  wire tx = usart1_tx_enable_i & ~compat_mode_i;
  wire mem = ext_memory_enable_i & compat_mode_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_ss_in;
    slv |=> !portb_dir_o[0];
  endproperty
  a_ss_in: assert property (p_ss_in) else $error("ss not input");
  property p_ss_act;
    1 |=> serial_slave_active_o == $past(slv & ~portb_pin_i[0]);
  endproperty
  a_ss_act: assert property (p_ss_act) else $error("slave act");
  property p_ss_dir;
    mst |=> portb_dir_o[0] == $past(portb_direction_i[0]);
  endproperty
  a_ss_dir: assert property (p_ss_dir) else $error("ss dir");
  property p_miso;
    slv |=> portb_val_o[3] == $past(serial_slave_data_i);
  endproperty
  a_miso: assert property (p_miso) else $error("miso value");
  property p_pb_hi;
    1 |=> portb_dir_o[7:4] == $past(portb_direction_i[7:4]);
  endproperty
  a_pb_hi: assert property (p_pb_hi) else $error("pb hi dir");
  property p_legacy;
    compat_mode_i |=> portc_dir_o == 8'hFF;
  endproperty
  a_legacy: assert property (p_legacy) else $error("pc dir");
  property p_addr;
    mem |=> portc_val_o == $past(ext_address_high_i);
  endproperty
  a_addr: assert property (p_addr) else $error("pc addr");
  property p_tx;
    tx |=> portd_dir_o[3] && portd_val_o[3] == $past(usart1_tx_data_i);
  endproperty
  a_tx: assert property (p_tx) else $error("tx pin");
  c_slave: cover property (slv && !portb_pin_i[0]);
  c_mem: cover property (mem);
  c_tx: cover property (tx);
endmodule

/* File: pmux_pin_model.sv */
`timescale 1ns/1ps
// outside party: drives every pin the device leaves as an input
module pmux_pin_model (
  input wire [7:0] dir_i,
  input wire [7:0] val_i,
  input wire [7:0] ext_i,
  output wire [7:0] pin_o
);
  assign pin_o = (dir_i & val_i) | (~dir_i & ext_i);
endmodule

/* File: pmux_top_bench.sv */
`timescale 1ns/1ps
module pmux_top_bench;
  typedef struct packed {
    logic cm, pdis;
    logic [7:0] bdir, bout, bext, cdir, cout, ddir, dout, dext;
    logic c0, en0, o1a, e1a, o1b, e1b, o1c, e1c, c2, en2;
    logic son, ms, sdat, mdat, sclk, mem;
    logic [2:0] msk;
    logic [7:0] adr;
    logic syn, xclk, txe, txd, rxe;
  } pmux_in_t;
  typedef struct packed {
    logic [7:0] bpu, bdir, bval, cpu, cdir, cval, dpu, ddir, dval;
    logic mi, si, ci, act, cnt2, cnt1, cap, xin, xout, rx, i3, i2;
  } pmux_out_t;
  logic mclk;
  logic rst;
  pmux_in_t s;
  wire pmux_out_t o;
  wire [7:0] pb;
  wire [7:0] pd;
  pmux_out_t q[$];
  pmux_out_t prev;
  logic [31:0] rnd;
  int error_cnt;
  int num_checks;
  pmux_top u_pmux_top (
    .mclk_i(mclk), .rst_i(rst), .compat_mode_i(s.cm),
    .global_pullup_disable_i(s.pdis), .portb_direction_i(s.bdir),
    .portb_output_value_i(s.bout), .portb_pin_i(pb),
    .portc_direction_i(s.cdir), .portc_output_value_i(s.cout),
    .portd_direction_i(s.ddir), .portd_output_value_i(s.dout),
    .portd_pin_i(pd), .timer0_compare_out_i(s.c0),
    .timer0_compare_en_i(s.en0), .timer1_compare_out_a_i(s.o1a),
    .timer1_compare_en_a_i(s.e1a), .timer1_compare_out_b_i(s.o1b),
    .timer1_compare_en_b_i(s.e1b), .timer1_compare_out_c_i(s.o1c),
    .timer1_compare_en_c_i(s.e1c), .timer2_compare_out_i(s.c2),
    .timer2_compare_en_i(s.en2), .serial_periph_on_i(s.son),
    .serial_master_select_i(s.ms), .serial_slave_data_i(s.sdat),
    .serial_master_data_i(s.mdat), .serial_clock_out_i(s.sclk),
    .ext_memory_enable_i(s.mem), .ext_address_mask_i(s.msk),
    .ext_address_high_i(s.adr), .usart1_sync_mode_i(s.syn),
    .usart1_ext_clock_out_i(s.xclk), .usart1_tx_enable_i(s.txe),
    .usart1_tx_data_i(s.txd), .usart1_rx_enable_i(s.rxe),
    .portb_pullup_o(o.bpu), .portb_dir_o(o.bdir), .portb_val_o(o.bval),
    .portc_pullup_o(o.cpu), .portc_dir_o(o.cdir), .portc_val_o(o.cval),
    .portd_pullup_o(o.dpu), .portd_dir_o(o.ddir), .portd_val_o(o.dval),
    .serial_master_in_o(o.mi), .serial_slave_in_o(o.si),
    .serial_clock_in_o(o.ci), .serial_slave_active_o(o.act),
    .timer2_count_in_o(o.cnt2), .timer1_count_in_o(o.cnt1),
    .timer1_capture_in_o(o.cap), .usart1_ext_clock_in_o(o.xin),
    .usart1_clock_is_out_o(o.xout), .usart1_receive_in_o(o.rx),
    .ext_irq_source_3_o(o.i3), .ext_irq_source_2_o(o.i2)
  );
  pmux_pin_model u_pmux_pin_model (
    .dir_i(o.bdir), .val_i(o.bval), .ext_i(s.bext), .pin_o(pb)
  );
  pmux_pin_model u_pmux_pin_model_d (
    .dir_i(o.ddir), .val_i(o.dval), .ext_i(s.dext), .pin_o(pd)
  );
  // pins seen next edge come from the previous expected outputs
  function automatic pmux_out_t model(pmux_in_t i, pmux_out_t p);
    pmux_out_t r;
    logic lg, u, e;
    logic [7:0] b, d, tk, np;
    logic [2:0] m;
    b = (p.bdir & p.bval) | (~p.bdir & i.bext);
    d = (p.ddir & p.dval) | (~p.ddir & i.dext);
    lg = i.cm;
    np = ~{8{i.pdis}};
    u = i.syn & ~lg;
    r.bdir = i.bdir;
    r.bval = i.bout;
    if (i.son) r.bdir[3:0] = i.bdir[3:0] & (i.ms ? 4'h7 : 4'h8);
    if (i.son & i.ms) begin
      r.bval[2] = i.mdat;
      r.bval[1] = i.sclk;
    end
    if (i.son & ~i.ms) r.bval[3] = i.sdat;
    if (i.en0) r.bval[4] = i.c0;
    if (i.e1a) r.bval[5] = i.o1a;
    if (i.e1b) r.bval[6] = i.o1b;
    e = i.e1c & ~lg;
    if (i.en2 | e) r.bval[7] = (i.en2 & i.c2) | (e & i.o1c);
    r.bpu = i.bout & ~r.bdir & np;
    m = lg ? 3'h0 : i.msk;
    for (int n = 0; n < 8; n++) tk[n] = i.mem & (m < (n < 2 ? 7 : 8 - n));
    r.cdir = (lg ? 8'hFF : i.cdir) | tk;
    r.cval = (i.cout & ~tk) | (i.adr & tk);
    r.cpu = i.cout & ~r.cdir & np;
    r.ddir = i.ddir;
    r.dval = i.dout;
    if (u) r.dval[5] = i.xclk;
    if (i.txe & ~lg) begin
      r.ddir[3] = 1'b1;
      r.dval[3] = i.txd;
    end
    if (i.rxe & ~lg) r.ddir[2] = 1'b0;
    r.dpu = i.dout & ~r.ddir & np;
    {r.mi, r.si, r.ci} = b[3:1];
    r.act = i.son & ~i.ms & ~b[0];
    {r.cnt2, r.cnt1, r.cap} = {d[7:6], d[4]};
    r.xin = u & d[5];
    r.xout = u & i.ddir[5];
    r.rx = i.rxe & ~lg & d[2];
    {r.i3, r.i2} = d[3:2];
    return r;
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] x);
    for (int k = 0; k < 32; k++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    return x;
  endfunction
  task automatic chk(string nm, pmux_out_t exp_v, pmux_out_t got);
    num_checks++;
    if (got !== exp_v) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp_v, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic drive(int cycles);
    logic [127:0] w;
    repeat (cycles) begin
      @(posedge mclk);
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        w = {w[95:0], rnd};
      end
      s <= w[97:0];
      prev = model(w[97:0], prev);
      q.push_back(prev);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // one edge of latency: compare once the next note has been queued
  always @(negedge mclk) begin
    if (q.size() > 1) chk("pin_outputs", q.pop_front(), o);
  end
  initial begin
    #500000;
    error_cnt++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    s = '0;
    rnd = 32'h3;
    prev = '0;
    prev.cdir = 8'hFF;
    repeat (5) @(posedge mclk);
    #1 chk("reset", prev, o);
    @(posedge mclk);
    rst <= 1'b0;
    prev = model(s, prev);
    drive(2000);
    complete_run();
  end
endmodule
bind pmux_top pmux_checker u_pmux_checker (.*);
